// [verilog/rdm_debug_port_mux.sv]
// Top of the radio core debug port multiplexer with its register port.
//
// How it works
// - Disabled word drives zeros, enabled drives source.
// - Word 7 source bits 29:24, enable 31.
// - Words 6,5,4 sources/enables in lower lanes.
// - Port bit 7 picks word 7 bit.
// - Port bit n select at 4n+2:4n.
// - Port bit n invert flag at 4n+3.
// - Fields reset zero, reserved bits read zero.
// - Override bit set overrules port mapping.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
module rdm_debug_port_mux #(
  parameter int NSRC = 64 // Number of selectable internal signal groups.
) (
  // Clock, reset and clock enable.
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rstn,
  input  wire logic                 i_ce,
  // Register port.
  input  wire logic [31:0]          i_addr,
  input  wire logic [31:0]          i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic      [31:0]          o_rdata,
  // Diagnostic sources: fixed words 0..3 and groups for words 4..7.
  input  wire logic [4*8-1:0]       i_fixed_words,
  input  wire logic [NSRC*8-1:0]    i_src_groups,
  // Word used while the override bit is set.
  input  wire logic [7:0]           i_override_word,
  // Diagnostic port pins.
  output logic      [7:0]           o_debug_port
);

  rdm_pkg::rdm_bus_req_s req; // Bundled bus request.
  logic [31:0] wsel_r;   // Upper word select register.
  logic [31:0] wsel_nxt;
  logic [31:0] bsel_r;   // Port bit select register.
  logic [31:0] bsel_nxt;
  logic [31:0] ovr_r;    // Override control register.
  logic [31:0] ovr_nxt;
  logic [31:0] rdata_r;  // Read data, valid one cycle after the strobe.
  logic [31:0] rdata_nxt;
  logic [8*8-1:0] words; // The eight diagnostic words side by side.
  logic [7:0]  lane_bits; // Registered lane outputs.
  logic        ovr_q;     // Override applied in step with the lanes.
  logic        ovr_q_nxt;
  logic [7:0]  ovr_word_q; // Override word registered with the lanes.
  logic [7:0]  ovr_word_nxt;

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  // Register writes and read decode; unmapped addresses read as zero.
  always_comb begin
    wsel_nxt  = wsel_r;
    bsel_nxt  = bsel_r;
    ovr_nxt   = ovr_r;
    rdata_nxt = rdata_r;
    if (i_ce) begin
      rdata_nxt = 32'h00000000;
      if (req.wr) begin
        case (req.addr)
          rdm_pkg::ADDR_WORD_SEL:
            wsel_nxt = req.wdata & rdm_pkg::MASK_WORD_SEL;
          rdm_pkg::ADDR_BIT_SEL:
            bsel_nxt = req.wdata & rdm_pkg::MASK_BIT_SEL;
          rdm_pkg::ADDR_OVERRIDE:
            ovr_nxt  = req.wdata & rdm_pkg::MASK_OVERRIDE;
          default: begin
            // Writes to other addresses are dropped.
          end
        endcase
      end
      if (req.rd) begin
        case (req.addr)
          rdm_pkg::ADDR_WORD_SEL: rdata_nxt = wsel_r;
          rdm_pkg::ADDR_BIT_SEL:  rdata_nxt = bsel_r;
          rdm_pkg::ADDR_OVERRIDE: rdata_nxt = ovr_r;
          default:                rdata_nxt = 32'h00000000;
        endcase
      end
    end
  end

  // Register state; all fields come out of reset at zero.
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      wsel_r  <= rdm_pkg::RST_WORD_SEL;
      bsel_r  <= rdm_pkg::RST_BIT_SEL;
      ovr_r   <= rdm_pkg::RST_OVERRIDE;
      rdata_r <= 32'h00000000;
    end else begin
      wsel_r  <= wsel_nxt;
      bsel_r  <= bsel_nxt;
      ovr_r   <= ovr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign o_rdata = rdata_r;

  // Words 0..3 come straight in; they have no enable and are never gated.
  assign words[4*8-1:0] = i_fixed_words;

  // Words 4..7 are chosen by their source select and gated by their enable.
  // An out-of-range select yields zero instead of an unknown index.
  genvar gw;
  generate
    for (gw = 0; gw < 4; gw++) begin : g_word
      logic [5:0] src;
      logic       en;
      assign src = wsel_r[gw*8 +: 6];
      assign en  = wsel_r[gw*8 + rdm_pkg::WSEL_EN_POS];
      assign words[(gw+4)*8 +: 8] =
        (en && (int'(src) < NSRC)) ?
          i_src_groups[int'(src)*8 +: 8] : 8'h00;
    end
  endgenerate

  // One lane per port bit; bit 7 reads word 7 through bits 30:28.
  genvar gl;
  generate
    for (gl = 0; gl < 8; gl++) begin : g_lane
      rdm_bit_lane #(
        .WORD_W (8)
      ) u_lane (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_ce      (i_ce),
        .i_word    (words[gl*8 +: 8]),
        .i_sel     (bsel_r[gl*4 +: 3]),
        .i_inv     (bsel_r[gl*4 + 3]),
        .o_bit     (lane_bits[gl])
      );
    end
  endgenerate

  // Override state is registered alongside the lanes so both switch together.
  always_comb begin
    ovr_q_nxt    = ovr_q;
    ovr_word_nxt = ovr_word_q;
    if (i_ce) begin
      ovr_q_nxt    = ovr_r[0];
      ovr_word_nxt = i_override_word;
    end
  end

  // Override stage registers.
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      ovr_q      <= 1'b0;
      ovr_word_q <= 8'h00;
    end else begin
      ovr_q      <= ovr_q_nxt;
      ovr_word_q <= ovr_word_nxt;
    end
  end

  // The override word replaces the mapped port while the bit is set.
  assign o_debug_port = ovr_q ? ovr_word_q : lane_bits;

  // Disabled word 7 with no inversion gives a zero port bit 7.
  // Each next-cycle antecedent also needs reset released at its own edge, because the
  // lanes still sit in reset at that edge and would not follow the sources.
  AST_WORD_DISABLED_ZERO: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (i_rstn && i_ce && !wsel_r[31] && !bsel_r[31] && !ovr_r[0])
      |=> (ovr_q || !lane_bits[7]))
    else $error("Disabled word 7 drove port bit 7.");

  // Enabled word 7 forwards the chosen source bit.
  AST_WORD7_SOURCE: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (i_rstn && i_ce && wsel_r[31] && int'(wsel_r[29:24]) < NSRC)
      |=> lane_bits[7] == ($past(i_src_groups[int'(wsel_r[29:24])*8
           + int'(bsel_r[30:28])]) ^ $past(bsel_r[31])))
    else $error("Port bit 7 does not follow word 7 source.");

  // Word 4 gates on bit 7 and selects with bits 5:0.
  AST_WORD4_GATE: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (i_ce && !wsel_r[7]) |-> words[39:32] == 8'h00)
    else $error("Word 4 not zero while disabled.");

  // Port bit 0 follows word 0 with its selector and invert.
  AST_BIT0_PICK: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (i_rstn && i_ce)
      |=> lane_bits[0] == ($past(i_fixed_words[bsel_r[2:0]])
                           ^ $past(bsel_r[3])))
    else $error("Port bit 0 pick wrong.");

  // Flipping only the invert flag of bit 2 flips the output.
  AST_BIT2_INVERT: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (i_rstn && i_ce)
      |=> lane_bits[2] == ($past(words[16 + int'(bsel_r[10:8])])
                           ^ $past(bsel_r[11])))
    else $error("Port bit 2 invert wrong.");

  // Reserved bits of the word select register always read zero.
  AST_RESERVED_ZERO: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (wsel_r & ~rdm_pkg::MASK_WORD_SEL) == 32'h00000000)
    else $error("Reserved bits set in word select register.");

  // A held override bit shows the override word on the next cycle.
  AST_OVERRIDE: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (i_rstn && i_ce && ovr_r[0]) |=> o_debug_port == $past(i_override_word))
    else $error("Override word not on port.");

  // Port bit 4 is one registered copy of word 4 pick.
  AST_ONE_STAGE: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (i_rstn && i_ce && !ovr_r[0]) |=> !ovr_q ##0 lane_bits[4] ==
      ($past(words[32 + int'(bsel_r[18:16])]) ^ $past(bsel_r[19])))
    else $error("Port bit 4 not a single register stage.");

endmodule

// [shared/rdm_pkg.sv]
// Package with register map, field layout and carrier types of the debug port mux.
package rdm_pkg;

  // Register byte addresses on the system bus.
  localparam logic [31:0] ADDR_WORD_SEL   = 32'h4000020C;
  localparam logic [31:0] ADDR_BIT_SEL    = 32'h40000210;
  localparam logic [31:0] ADDR_OVERRIDE   = 32'h40000214;

  // Reset values of the registers.
  localparam logic [31:0] RST_WORD_SEL    = 32'h00000000;
  localparam logic [31:0] RST_BIT_SEL     = 32'h00000000;
  localparam logic [31:0] RST_OVERRIDE    = 32'h00000000;

  // Writable bits of each register; reserved bits read as zero.
  localparam logic [31:0] MASK_WORD_SEL   = 32'hBFBFBFBF;
  localparam logic [31:0] MASK_BIT_SEL    = 32'hFFFFFFFF;
  localparam logic [31:0] MASK_OVERRIDE   = 32'h00000001;

  // Field layout of the upper word select register, per byte lane.
  localparam int WSEL_LANE_W   = 8;
  localparam int WSEL_SRC_LSB  = 0;
  localparam int WSEL_SRC_W    = 6;
  localparam int WSEL_EN_POS   = 7;
  localparam int WSEL_FIRST    = 4;

  // Field layout of the port bit select register, per nibble.
  localparam int BSEL_LANE_W   = 4;
  localparam int BSEL_SEL_LSB  = 0;
  localparam int BSEL_SEL_W    = 3;
  localparam int BSEL_INV_POS  = 3;

  // Port geometry.
  localparam int PORT_W        = 8;
  localparam int WORD_W        = 8;

  // Fixed read latency of the register port in cycles.
  localparam int RD_LATENCY    = 1;

  // Register bus request carried as one bundle.
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rdm_bus_req_s;

endpackage

// [verilog/rdm_bit_lane.sv]
// One lane of the debug port: bit pick, optional invert, output flop.
`timescale 1ns/100ps
module rdm_bit_lane #(
  parameter int WORD_W = 8
) (
  // Clock, reset and enable.
  input  wire logic              i_clk_sys,
  input  wire logic              i_rstn,
  input  wire logic              i_ce,
  // Diagnostic word and lane controls.
  input  wire logic [WORD_W-1:0] i_word,
  input  wire logic [2:0]        i_sel,
  input  wire logic              i_inv,
  // Registered port bit.
  output logic                   o_bit
);

  logic bit_r;   // Registered lane value.
  logic bit_nxt; // Next lane value.

  // Pick the chosen bit and flip it when the invert flag is set.
  always_comb begin
    bit_nxt = bit_r;
    if (i_ce) begin
      bit_nxt = i_word[i_sel] ^ i_inv;
    end
  end

  // One register stage keeps the pin free of select glitches.
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      bit_r <= 1'b0;
    end else begin
      bit_r <= bit_nxt;
    end
  end

  assign o_bit = bit_r;

endmodule

// [tb/rdm_port_observer.sv]
// Observer model of the external pins of the diagnostic port.
`timescale 1ns/100ps
module rdm_port_observer (
  // Clock and reset of the observer.
  input  wire logic       i_clk_sys,
  input  wire logic       i_rstn,
  // Diagnostic port pins as seen from outside.
  input  wire logic [7:0] i_port,
  // Last value captured and number of changes seen.
  output logic      [7:0] o_seen,
  output logic      [15:0] o_changes
);
  // The observer only listens; it never drives the pins back.
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_seen    <= 8'h00;
      o_changes <= 16'h0000;
    end else begin
      // A change counter shows the port is really moving in the run.
      if (o_seen !== i_port) begin
        o_changes <= o_changes + 16'h0001;
      end
      o_seen <= i_port;
    end
  end
endmodule

// [tb/tb_radio_core_debug_port_mux.sv]
// Self-checking bench of the debug port multiplexer.
`timescale 1ns/100ps
module tb_radio_core_debug_port_mux;
  logic         clk, rstn, ce, wr, rd;
  logic [31:0]  addr, wdata, rdata, ws, bs, ov, d;
  logic [31:0]  fixw;
  logic [511:0] grp;
  logic [7:0]   ovw, port, seen;
  logic [15:0]  chg;
  int           err_count, n_compared, i;

  // Clock of 200 MHz.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  rdm_debug_port_mux #(.NSRC(64)) u_dut (
    .i_clk_sys(clk), .i_rstn(rstn), .i_ce(ce), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_fixed_words(fixw), .i_src_groups(grp),
    .i_override_word(ovw), .o_debug_port(port));

  rdm_port_observer u_obs (
    .i_clk_sys(clk), .i_rstn(rstn), .i_port(port), .o_seen(seen),
    .o_changes(chg));

  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One-cycle write on the register port.
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // One-cycle read; data stand only in the cycle after the strobe.
  task automatic rd_reg(input logic [31:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask

  // Reference port value worked out from the settings and sources.
  function automatic logic [7:0] model();
    logic [7:0] wd, r;
    int         w;
    for (int n = 0; n < 8; n++) begin
      if (n < 4) begin
        wd = fixw[8*n +: 8];
      end else begin
        w  = int'(ws >> (8 * (n - 4)));
        wd = w[7] ? grp[(w & 63) * 8 +: 8] : 8'h00;
      end
      r[n] = wd[bs[4*n +: 3]] ^ bs[4*n+3];
    end
    return ov[0] ? ovw : r;
  endfunction

  // Closing verdict; the only place the run ends.
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog: a hang counts as a mismatch.
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    report_and_stop();
  end

  initial begin
    {rstn, wr, rd, addr, wdata, fixw, grp, ovw} = '0;
    ce = 1'b1;
    {ws, bs, ov} = '0;
    err_count = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    void'($urandom(50408));
    // Reset values, and an unmapped place reads zero.
    rd_reg(rdm_pkg::ADDR_WORD_SEL, d);
    chk("wsel_rst", d, rdm_pkg::RST_WORD_SEL);
    // Read data stand one cycle only, then fall back to zero.
    @(negedge clk);
    chk("rd_drop", rdata, 32'h00000000);
    rd_reg(rdm_pkg::ADDR_BIT_SEL, d);
    chk("bsel_rst", d, rdm_pkg::RST_BIT_SEL);
    rd_reg(32'h40000218, d);
    chk("unmapped", d, 32'h00000000);
    chk("port_rst", {24'h000000, port}, 32'h00000000);
    $display("test reset done");
    // Reserved bits of the word select read back as zero.
    wr_reg(rdm_pkg::ADDR_WORD_SEL, 32'hFFFFFFFF);
    rd_reg(rdm_pkg::ADDR_WORD_SEL, d);
    chk("wsel_rsvd", d, 32'hBFBFBFBF);
    wr_reg(rdm_pkg::ADDR_BIT_SEL, 32'hFFFFFFFF);
    rd_reg(rdm_pkg::ADDR_BIT_SEL, d);
    chk("bsel_rw", d, 32'hFFFFFFFF);
    $display("test access done");
    // Random mapping: enables, sources, bit picks and inversion.
    for (i = 0; i < 60; i++) begin
      ws = $urandom;
      bs = $urandom;
      @(posedge clk);
      fixw <= $urandom;
      for (int k = 0; k < 16; k++) begin
        grp[32*k +: 32] <= $urandom;
      end
      wr_reg(rdm_pkg::ADDR_WORD_SEL, ws);
      wr_reg(rdm_pkg::ADDR_BIT_SEL, bs);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("port_map", {24'h000000, port}, {24'h000000, model()});
      chk("observer", {24'h000000, seen}, {24'h000000, model()});
    end
    $display("test mapping done");
    // Override overrules the mapping, then releases it.
    for (i = 0; i < 2; i++) begin
      ov = 32'h00000001 - i;
      @(posedge clk);
      ovw <= 8'($urandom);
      wr_reg(rdm_pkg::ADDR_OVERRIDE, ov);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("port_ovr", {24'h000000, port}, {24'h000000, model()});
    end
    rd_reg(rdm_pkg::ADDR_OVERRIDE, d);
    chk("ovr_rd", d, 32'h00000000);
    chk("moved", 32'(chg != 16'h0000), 32'h00000001);
    $display("test override done");
    // Clock enable low freezes registers and port against new sources.
    d = {24'h000000, port};
    @(posedge clk);
    ce   <= 1'b0;
    fixw <= ~fixw;
    grp  <= ~grp;
    wr_reg(rdm_pkg::ADDR_BIT_SEL, ~bs);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("ce_port", {24'h000000, port}, d);
    @(posedge clk);
    ce <= 1'b1;
    rd_reg(rdm_pkg::ADDR_BIT_SEL, d);
    chk("ce_hold", d, bs);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("ce_resume", {24'h000000, port}, {24'h000000, model()});
    $display("test clock enable done");
    // A reset in mid-run clears every register again.
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    {ws, bs} = '0;
    rd_reg(rdm_pkg::ADDR_WORD_SEL, d);
    chk("wsel_rst2", d, rdm_pkg::RST_WORD_SEL);
    rd_reg(rdm_pkg::ADDR_BIT_SEL, d);
    chk("bsel_rst2", d, rdm_pkg::RST_BIT_SEL);
    chk("port_rst2", {24'h000000, port}, {24'h000000, model()});
    $display("test mid reset done");
    report_and_stop();
  end
endmodule
